// *** ptc_pkg.sv ***
// Shared constants and carriers for the tone sample capture block
package ptc_pkg;
	localparam int CHANS = 32;
	localparam int SAMPLES = 288;
	localparam int RD_LEN = 192;
	localparam int WIN_STEP = 96;
	localparam int CH_W = 5;
	localparam int IDX_W = 9;
	localparam int BA_W = 14;
	localparam int MEM_AW = 15;
	localparam int CLK_NS = 50;
	localparam int FRAME_NS = 125000;
	localparam int WINDOW_MS = 12;
	localparam int WIN_FRAMES = WINDOW_MS * 1000000 / FRAME_NS;
	localparam int FLASH_NS = 150;
	localparam int FLASH_WAIT = (FLASH_NS + CLK_NS - 1) / CLK_NS;
	localparam int CTRL_LAW = 0;
	localparam int CTRL_PAIR = 1;
	localparam int CTRL_NAT = 2;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [CH_W-1:0] CH_MSG0 = 5'h00;
	localparam logic [CH_W-1:0] CH_MSG1 = 5'h10;
	localparam logic [1:0] OWN_NONE = 2'h0;
	localparam logic [1:0] OWN_LP = 2'h1;
	localparam logic [1:0] OWN_SP = 2'h2;
	// Voice bus: ports 16..19 in lanes 0..3
	typedef struct packed {
		logic frame;
		logic slot;
		logic [3:0][7:0] data;
	} ptc_vbus_t;
	typedef struct packed {
		logic req;
		logic sel;
		logic [CH_W-1:0] ch;
		logic [IDX_W-1:0] idx;
	} ptc_rd_t;
	typedef struct packed {
		logic req;
		logic [10:0] addr;
	} ptc_dp_t;
	typedef enum logic [1:0] {
		S_HDR = 2'b00,
		S_COPY = 2'b01,
		S_TEST = 2'b11,
		S_RUN = 2'b10
	} ptc_state_t;
endpackage

// *** ptc_capture.sv ***
// Tone sample capture, boot copier and shared memory arbiter
// Notes on behaviour
// - store all 32 channels of each port
// - listen to port pair 16/17 or 18/19
// - national mode skips channels 0 and 16
// - one 16K buffer per pair port, 9K used
// - 288 samples held per channel, linear
// - processor reads 192 consecutive samples per slot
// - all 32 channels processed each 12 ms, 30 in national mode
// - read start advances 96 samples per window
// - both pair ports latched every channel time
// - reads must finish before 96 new samples
// - after reset copy flash firmware to memory
// - download only while in post-reset test loop
// - main memory is 32-bit wide block
// - main memory runs three times flash rate
// - 8-bit control register selects law, pair
// - shared memory: same-address owner keeps access, lp wins if neither owns, other waits
module ptc_capture import ptc_pkg::*; #(
	parameter int NCH = CHANS,
	parameter int NSMP = SAMPLES
) (
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire ptc_vbus_t i_vbus,
	input wire logic i_ctrl_wr,
	input wire logic [7:0] i_ctrl_data,
	input wire ptc_rd_t i_rd,
	input wire logic [7:0] i_flash_data,
	input wire logic i_dl_wr,
	input wire logic [7:0] i_dl_data,
	input wire logic i_test_exit,
	input wire ptc_dp_t i_lp_dp,
	input wire ptc_dp_t i_sp_dp,
	output logic [7:0] o_rd_data,
	output logic o_rd_valid,
	output logic o_win_tick,
	output logic o_lost,
	output logic [7:0] o_ctrl,
	output logic [16:0] o_flash_addr,
	output logic o_flash_we,
	output logic [7:0] o_flash_wdata,
	output logic [MEM_AW-1:0] o_mem_addr,
	output logic [31:0] o_mem_wdata,
	output logic o_mem_we,
	output logic o_test_loop,
	output logic o_lp_grant,
	output logic o_sp_grant
);
	// Linear buffer address of a sample
	function automatic logic [BA_W-1:0] buf_addr(input logic [CH_W-1:0] ch, input logic [IDX_W-1:0] idx);
		buf_addr = BA_W'(ch * NSMP + idx);
	endfunction
	function automatic logic [IDX_W-1:0] wrap(input logic [IDX_W:0] v);
		wrap = (v >= (IDX_W+1)'(NSMP)) ? IDX_W'(v - (IDX_W+1)'(NSMP)) : v[IDX_W-1:0];
	endfunction
	function automatic logic is_msg(input logic [CH_W-1:0] ch);
		is_msg = (ch == CH_MSG0) || (ch == CH_MSG1);
	endfunction

	logic [7:0] bufm [2][NCH*NSMP];
	ptc_vbus_t vb_s1, vb_s2;
	logic slot_d;
	logic [7:0] ctrl, next_ctrl;
	logic [CH_W-1:0] wr_ch, next_wr_ch, exp_ch, next_exp_ch;
	logic [IDX_W-1:0] wr_idx, next_wr_idx, rd_base, next_rd_base;
	logic [6:0] frames, next_frames;
	logic done, next_done, win_tick, next_win_tick, lost, next_lost;
	logic wr_en;
	logic [CH_W-1:0] cur_ch;
	logic [BA_W-1:0] wr_addr;
	logic [7:0] wr_a, wr_b;

	// Pins cross two flops; the edge detect compares the second with its delayed copy slot_d
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			vb_s1 <= '0;
			vb_s2 <= '0;
			slot_d <= 1'b0;
		end else begin
			vb_s1 <= i_vbus;
			vb_s2 <= vb_s1;
			slot_d <= vb_s2.slot;
		end
	end

	// Control register, law and pair select held for the processor
	always_comb begin
		next_ctrl = i_ctrl_wr ? i_ctrl_data : ctrl;
	end
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) ctrl <= CTRL_RST;
		else ctrl <= next_ctrl;
	end

	// Writer: one sample per channel time from both ports of the pair
	always_comb begin
		wr_en = vb_s2.slot && !slot_d;
		cur_ch = vb_s2.frame ? CH_MSG0 : CH_W'(wr_ch + 5'h01);
		wr_addr = buf_addr(cur_ch, wr_idx);
		wr_a = ctrl[CTRL_PAIR] ? vb_s2.data[2] : vb_s2.data[0];
		wr_b = ctrl[CTRL_PAIR] ? vb_s2.data[3] : vb_s2.data[1];
		next_wr_ch = wr_en ? cur_ch : wr_ch;
		next_wr_idx = wr_idx;
		next_frames = frames;
		next_rd_base = rd_base;
		next_win_tick = 1'b0;
		next_lost = lost;
		if (wr_en && cur_ch == CH_W'(NCH - 1)) begin
			next_wr_idx = wrap({1'b0, wr_idx} + 10'h001);
			next_frames = frames + 7'h01;
			if (frames == 7'(WIN_FRAMES - 1)) begin
				next_frames = 7'h00;
				next_rd_base = wrap({1'b0, rd_base} + 10'(WIN_STEP));
				next_win_tick = 1'b1;
				next_lost = lost || !done;
			end
		end
	end
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			wr_ch <= '0;
			wr_idx <= '0;
			frames <= '0;
			rd_base <= '0;
			win_tick <= 1'b0;
			lost <= 1'b0;
		end else begin
			wr_ch <= next_wr_ch;
			wr_idx <= next_wr_idx;
			frames <= next_frames;
			rd_base <= next_rd_base;
			win_tick <= next_win_tick;
			lost <= next_lost;
		end
	end
	// Storage has no reset; contents before the first frame are stale
	always_ff @(posedge i_ref_clk) begin
		if (wr_en) begin
			bufm[0][wr_addr] <= wr_a;
			bufm[1][wr_addr] <= wr_b;
		end
	end

	// Reader: window of 192 from the shifting base, channels in order
	logic rd_ok;
	logic [7:0] rd_q;
	always_comb begin
		rd_ok = i_rd.req && (i_rd.idx < IDX_W'(RD_LEN)) && !(ctrl[CTRL_NAT] && is_msg(i_rd.ch));
		rd_q = bufm[i_rd.sel][buf_addr(i_rd.ch, wrap({1'b0, rd_base} + {1'b0, i_rd.idx}))];
		next_exp_ch = exp_ch;
		next_done = done;
		if (win_tick) begin
			next_exp_ch = CH_MSG0;
			next_done = 1'b0;
		end else if (rd_ok && i_rd.ch == exp_ch && i_rd.idx == IDX_W'(RD_LEN - 1) && !done) begin
			next_exp_ch = CH_W'(exp_ch + 5'h01);
			if (ctrl[CTRL_NAT] && is_msg(CH_W'(exp_ch + 5'h01))) next_exp_ch = CH_W'(exp_ch + 5'h02);
			next_done = (exp_ch == CH_W'(NCH - 1));
		end
		if (ctrl[CTRL_NAT] && next_exp_ch == CH_MSG0 && !next_done) next_exp_ch = 5'h01;
	end
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			exp_ch <= '0;
			done <= 1'b0;
			o_rd_data <= 8'h00;
			o_rd_valid <= 1'b0;
		end else begin
			exp_ch <= next_exp_ch;
			done <= next_done;
			o_rd_data <= rd_ok ? rd_q : 8'h00;
			o_rd_valid <= rd_ok;
		end
	end

	// Boot: header gives word count, bytes packed low first
	ptc_state_t st, next_st;
	logic [16:0] faddr, next_faddr;
	logic [1:0] wait_c, next_wait_c;
	logic [15:0] words, next_words;
	logic [1:0] bsel, next_bsel;
	logic [31:0] wacc, next_wacc;
	logic [MEM_AW-1:0] maddr, next_maddr;
	logic mwe, next_mwe, fwe, next_fwe, test_loop;
	logic [7:0] fwd, next_fwd;
	always_comb begin
		next_st = st;
		next_faddr = faddr;
		next_wait_c = wait_c;
		next_words = words;
		next_bsel = bsel;
		next_wacc = wacc;
		next_maddr = maddr;
		next_mwe = 1'b0;
		next_fwe = 1'b0;
		next_fwd = fwd;
		case (st)
			S_HDR, S_COPY: begin
				// Flash is slow: wait its access time per byte
				next_wait_c = wait_c + 2'h1;
				if (wait_c == 2'(FLASH_WAIT - 1)) begin
					next_wait_c = 2'h0;
					next_faddr = faddr + 17'h00001;
					if (st == S_HDR) begin
						next_words = {i_flash_data, words[15:8]};
						if (faddr[0]) next_st = (next_words == 16'h0000) ? S_TEST : S_COPY;
					end else begin
						next_wacc = {i_flash_data, wacc[31:8]};
						next_bsel = bsel + 2'h1;
						if (bsel == 2'h3) begin
							next_mwe = 1'b1;
							next_words = words - 16'h0001;
							if (words == 16'h0001) next_st = S_TEST;
						end
					end
				end
			end
			S_TEST: begin
				// Download rewrites flash only here
				if (i_dl_wr) begin
					next_fwe = 1'b1;
					next_fwd = i_dl_data;
				end
				if (i_test_exit) next_st = S_RUN;
			end
			S_RUN: next_st = S_RUN;
			default: next_st = S_HDR;
		endcase
		if (mwe) next_maddr = maddr + MEM_AW'(1);
		if (fwe) next_faddr = faddr + 17'h00001;
		if (st != S_TEST && next_st == S_TEST) next_faddr = 17'h00000;
	end
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			st <= S_HDR;
			faddr <= '0;
			wait_c <= '0;
			words <= '0;
			bsel <= '0;
			wacc <= '0;
			maddr <= '0;
			mwe <= 1'b0;
			fwe <= 1'b0;
			fwd <= 8'h00;
			test_loop <= 1'b0;
		end else begin
			st <= next_st;
			faddr <= next_faddr;
			wait_c <= next_wait_c;
			words <= next_words;
			bsel <= next_bsel;
			wacc <= next_wacc;
			maddr <= next_maddr;
			mwe <= next_mwe;
			fwe <= next_fwe;
			fwd <= next_fwd;
			test_loop <= (next_st == S_TEST);
		end
	end

	// Shared memory arbiter; only same-address access contends
	ptc_dp_t sp_s1, sp_s2;
	logic [1:0] own, next_own;
	logic same, next_lpg, next_spg, lpg, spg;
	always_comb begin
		same = i_lp_dp.addr == sp_s2.addr;
		next_own = own;
		if (own == OWN_LP && !i_lp_dp.req) next_own = OWN_NONE;
		if (own == OWN_SP && !sp_s2.req) next_own = OWN_NONE;
		if (next_own == OWN_NONE && same && i_lp_dp.req) next_own = OWN_LP;
		else if (next_own == OWN_NONE && same && sp_s2.req) next_own = OWN_SP;
		next_lpg = i_lp_dp.req && !(same && next_own == OWN_SP);
		next_spg = sp_s2.req && !(same && next_own == OWN_LP);
	end
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			sp_s1 <= '0;
			sp_s2 <= '0;
			own <= OWN_NONE;
			lpg <= 1'b0;
			spg <= 1'b0;
		end else begin
			sp_s1 <= i_sp_dp;
			sp_s2 <= sp_s1;
			own <= next_own;
			lpg <= next_lpg;
			spg <= next_spg;
		end
	end

	assign o_win_tick = win_tick;
	assign o_lost = lost;
	assign o_ctrl = ctrl;
	assign o_flash_addr = faddr;
	assign o_flash_we = fwe;
	assign o_flash_wdata = fwd;
	assign o_mem_addr = maddr;
	assign o_mem_wdata = wacc;
	assign o_mem_we = mwe;
	assign o_test_loop = test_loop;
	assign o_lp_grant = lpg;
	assign o_sp_grant = spg;

	// Checks
	a_base_step: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		win_tick |-> rd_base == wrap({1'b0, $past(rd_base)} + 10'(WIN_STEP)))
		else $error("read base did not step by 96");
	a_idx_wrap: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		wr_idx < IDX_W'(NSMP))
		else $error("write index out of channel region");
	a_lost_late: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(next_win_tick && !done) |=> lost)
		else $error("late window not flagged");
	a_read_lat: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		rd_ok |=> o_rd_valid ##1 (o_rd_valid == $past(rd_ok)))
		else $error("read answer timing wrong");
	a_nat_skip: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(i_rd.req && ctrl[CTRL_NAT] && is_msg(i_rd.ch)) |=> !o_rd_valid)
		else $error("message channel was read");
	a_dl_gate: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		fwe |-> $past(st) == S_TEST)
		else $error("download outside test loop");
	a_mem_pack: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		mwe |-> (st == S_COPY || st == S_TEST) && $past(bsel) == 2'h3)
		else $error("word written before four bytes");
	a_no_clash: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		!(next_lpg && next_spg && same))
		else $error("both sides granted same location");
	a_frame_cnt: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		frames < 7'(WIN_FRAMES))
		else $error("window longer than 96 frames");
endmodule // ptc_capture

// *** ptc_switch_model.sv ***
// Time switch and flash model facing the capture block
module ptc_switch_model import ptc_pkg::*; (
	input wire logic i_ref_clk,
	input wire logic i_run,
	input wire logic [16:0] i_flash_addr,
	output ptc_vbus_t o_vbus,
	output logic [7:0] o_flash_data,
	output int o_frm
);
	logic [3:0] cyc = 4'h0;
	logic [4:0] ch = 5'h00;
	logic slot = 1'b0;
	int nfrm = 0;
	assign o_frm = nfrm;
	// Short channel times keep a 96 frame window affordable
	always @(negedge i_ref_clk) begin
		if (i_run) begin
			cyc <= cyc + 4'h1;
			slot <= cyc < 4'h7;
			if (cyc == 4'hf) begin
				ch <= ch + 5'h01;
				if (ch == 5'h1f) begin
					nfrm <= nfrm + 1;
				end
			end
		end
	end
	// Byte tags frame parity, lane and channel; steady across the slot
	assign o_vbus = {i_run && ch == 5'h00, slot, nfrm[0], 2'h3, ch, nfrm[0], 2'h2, ch,
		nfrm[0], 2'h1, ch, nfrm[0], 2'h0, ch};
	// One word boot image; other bytes read as the inverted address
	always_comb begin
		case (i_flash_addr)
			17'h00000: o_flash_data = 8'h01;
			17'h00001: o_flash_data = 8'h00;
			17'h00002: o_flash_data = 8'h11;
			17'h00003: o_flash_data = 8'h22;
			17'h00004: o_flash_data = 8'h33;
			17'h00005: o_flash_data = 8'h44;
			default: o_flash_data = ~i_flash_addr[7:0];
		endcase
	end
endmodule // ptc_switch_model

// *** pcm_tone_sample_capture_tb.sv ***
// Self-checking bench for the tone sample capture block
module pcm_tone_sample_capture_tb import ptc_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_ref_clk = 1'b0;
	logic i_rst = 1'b1;
	logic run = 1'b0, ctrl_wr = 1'b0, dl_wr = 1'b0, test_exit = 1'b0;
	logic [7:0] ctrl_data = 8'h00, dl_data = 8'h00, flash_data, rd_data, ctrl, fl_wdata;
	ptc_vbus_t vbus;
	ptc_rd_t rd = '0;
	ptc_dp_t lp = '0, sp = '0;
	logic rd_valid, win_tick, lost, fl_we, mem_we, test_loop, lp_grant, sp_grant;
	logic [16:0] fl_addr;
	logic [MEM_AW-1:0] mem_addr;
	logic [31:0] mem_wdata;
	int frm, error_cnt = 0, n_checks = 0, i;
	// 20 MHz reference
	always #25 i_ref_clk = ~i_ref_clk;
	ptc_capture dut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_vbus(vbus), .i_ctrl_wr(ctrl_wr),
		.i_ctrl_data(ctrl_data), .i_rd(rd), .i_flash_data(flash_data), .i_dl_wr(dl_wr),
		.i_dl_data(dl_data), .i_test_exit(test_exit), .i_lp_dp(lp), .i_sp_dp(sp),
		.o_rd_data(rd_data), .o_rd_valid(rd_valid), .o_win_tick(win_tick), .o_lost(lost),
		.o_ctrl(ctrl), .o_flash_addr(fl_addr), .o_flash_we(fl_we), .o_flash_wdata(fl_wdata),
		.o_mem_addr(mem_addr), .o_mem_wdata(mem_wdata), .o_mem_we(mem_we),
		.o_test_loop(test_loop), .o_lp_grant(lp_grant), .o_sp_grant(sp_grant));
	ptc_switch_model sw (.i_ref_clk(i_ref_clk), .i_run(run), .i_flash_addr(fl_addr),
		.o_vbus(vbus), .o_flash_data(flash_data), .o_frm(frm));
	task automatic stop_test();
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			$display("Error %s expected %h seen %h", nm, e, g);
			error_cnt++;
		end
	endtask
	// A wait that ran out ends the run
	task automatic tmo(input int k, input int n);
		if (k >= n) begin
			chk("wait bound", 0, 1);
			stop_test();
		end
	endtask
	task automatic cy(input int n);
		repeat (n) @(negedge i_ref_clk);
	endtask
	// Answer lands in the cycle after the request and stands for one cycle only
	task automatic rdc(input logic [4:0] c, input logic s, input logic [8:0] x, input logic v,
		input logic [7:0] e);
		rd = '{1'b1, s, c, x};
		cy(1);
		rd.req = 1'b0;
		chk("rd_valid", v, rd_valid);
		if (v) chk("rd_data", e, rd_data);
		cy(1);
		chk("rd_valid end", 0, rd_valid);
	endtask
	task automatic t_boot();
		for (i = 0; i < 400 && mem_we !== 1'b1; i++) cy(1);
		tmo(i, 400);
		chk("boot cycles", 6 * FLASH_WAIT, i);
		chk("mem_wdata", 32'h44332211, mem_wdata);
		chk("mem_addr", 0, mem_addr);
		for (i = 0; i < 40 && test_loop !== 1'b1; i++) cy(1);
		chk("test_loop", 1, test_loop);
	endtask
	task automatic t_dl(input logic [7:0] d, input logic v, input logic [16:0] a);
		dl_data = d;
		dl_wr = 1'b1;
		cy(1);
		dl_wr = 1'b0;
		for (i = 0; i < 3 && fl_we !== 1'b1; i++) cy(1);
		chk("flash_we", v, fl_we);
		if (v) chk("flash_wdata", {a, d}, {fl_addr, fl_wdata});
		cy(1);
	endtask
	task automatic t_ctrl(input logic [7:0] d);
		ctrl_data = d;
		ctrl_wr = 1'b1;
		cy(1);
		ctrl_wr = 1'b0;
		cy(2);
		chk("ctrl", d, ctrl);
	endtask
	task automatic t_frm(input int n);
		for (i = 0; i < 60000 && frm < n; i++) cy(1);
		tmo(i, 60000);
		cy(20);
	endtask
	task automatic t_arb();
		lp = '{1'b1, 11'h005};
		cy(3);
		chk("lp_grant", 1, lp_grant);
		sp = '{1'b1, 11'h005};
		cy(5);
		chk("grants", 2'b10, {lp_grant, sp_grant});
		lp.req = 1'b0;
		cy(5);
		chk("grants", 2'b01, {lp_grant, sp_grant});
		lp.req = 1'b1;
		cy(5);
		chk("grants", 2'b01, {lp_grant, sp_grant});
		sp.req = 1'b0;
		lp.req = 1'b0;
		cy(5);
	endtask
	initial begin
		cy(6);
		i_rst = 1'b0;
		t_boot();
		t_dl(8'h5a, 1'b1, 17'h00000);
		t_dl(8'ha5, 1'b1, 17'h00001);
		test_exit = 1'b1;
		cy(1);
		test_exit = 1'b0;
		cy(3);
		chk("test_loop", 0, test_loop);
		t_dl(8'h3c, 1'b0, 17'h00000);
		t_ctrl(8'h06);
		run = 1'b1;
		t_frm(2);
		for (int c = 5; c < 32; c += 26) begin
			for (int x = 0; x < 2; x++) begin
				rdc(5'(c), 1'b0, 9'(x), 1'b1, {x[0], 2'h2, c[4:0]});
				rdc(5'(c), 1'b1, 9'(x), 1'b1, {x[0], 2'h3, c[4:0]});
			end
		end
		rdc(5'h00, 1'b0, 9'h000, 1'b0, 8'h00);
		rdc(5'h10, 1'b1, 9'h001, 1'b0, 8'h00);
		rdc(5'h05, 1'b0, 9'h0c0, 1'b0, 8'h00);
		t_frm(3);
		t_ctrl(8'h00);
		t_frm(5);
		rdc(5'h10, 1'b0, 9'h004, 1'b1, 8'h10);
		rdc(5'h10, 1'b1, 9'h004, 1'b1, 8'h30);
		t_arb();
		for (i = 0; i < 60000 && win_tick !== 1'b1; i++) cy(1);
		tmo(i, 60000);
		// The model counts a frame only once channel 31 has ended
		chk("tick frame", WIN_FRAMES - 1, frm);
		chk("lost", 1, lost);
		t_frm(98);
		rdc(5'h05, 1'b0, 9'h001, 1'b1, 8'h85);
		stop_test();
	end
endmodule // pcm_tone_sample_capture_tb
